// ==== dasb_fifo.sv ====
module dasb_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  input wire logic  CLK,
  input wire logic  RST,
  dasb_fifo_if.fifo q
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
  } dasb_fifo_st_t;

  dasb_fifo_st_t st_reg;
  dasb_fifo_st_t st_next;
  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   count;
  logic          push;
  logic          pop;

  assign count    = st_reg.wptr - st_reg.rptr;
  assign q.wready = (count != (AW+1)'(DEPTH));
  assign q.rvalid = (count != '0);
  assign q.rdata  = mem[st_reg.rptr[AW-1:0]];
  assign push     = q.wvalid && q.wready;
  assign pop      = q.rvalid && q.rready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wptr = st_reg.wptr + 1'b1;
    end
    if (pop) begin
      st_next.rptr = st_reg.rptr + 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge CLK) begin
    if (push) begin
      mem[st_reg.wptr[AW-1:0]] <= q.wdata;
    end
  end

  // Holding flag drops only when the queue is full
  property p_full_blocks;
    @(posedge CLK) disable iff (RST)
    (count == (AW+1)'(DEPTH)) |-> !q.wready;
  endproperty
  a_full_blocks: assert property (p_full_blocks) else $error("queue full but still ready");
endmodule

// ==== dasb_fifo_if.sv ====
interface dasb_fifo_if #(
  parameter int W = 8
);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;

  modport fifo (input wdata, input wvalid, output wready, output rdata, output rvalid, input rready);
  modport src  (output wdata, output wvalid, input wready);
  modport snk  (input rdata, input rvalid, output rready);
endinterface

// ==== dasb_host.sv ====
module dasb_host (
  input  wire logic       CLK,
  output logic            CS_A_N,
  output logic            CS_B_N,
  output logic            RATE_CS_N,
  output logic            CTRL_DATA_SEL,
  output logic            RD_N,
  output logic            WR_N,
  output logic      [7:0] DATA_IN
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {CS_A_N, CS_B_N, RATE_CS_N, RD_N, WR_N} = 5'h1F;
    CTRL_DATA_SEL = 1'b0;
    DATA_IN = 8'h00;
  end

  // Target 0 channel A, 1 channel B, 2 rate registers
  task automatic access(input int tgt, input logic cd, input logic wr, input logic [7:0] d);
    @(negedge CLK);
    CS_A_N = tgt != 0;
    CS_B_N = tgt != 1;
    RATE_CS_N = tgt != 2;
    CTRL_DATA_SEL = cd;
    DATA_IN = d;
    repeat (2) @(negedge CLK);
    if (wr) begin
      WR_N = 1'b0;
    end else begin
      RD_N = 1'b0;
    end
    repeat (6) @(negedge CLK);
    {RD_N, WR_N} = 2'h3;
    repeat (5) @(negedge CLK);
    {CS_A_N, CS_B_N, RATE_CS_N} = 3'h7;
    DATA_IN = ~DATA_IN;
    CTRL_DATA_SEL = ~CTRL_DATA_SEL;
  endtask
endmodule

// ==== dasb_pkg.sv ====
package dasb_pkg;
  // Clock and crystal rates, in hertz
  localparam logic [27:0] CLK_HZ       = 28'hBEBC200;
  localparam logic [27:0] XTAL_HZ      = 28'h01C2000;
  localparam int          ACC_W        = 28;

  // Channel count, data width and transmit queue depth
  localparam int          NUM_CH       = 2;
  localparam int          DATA_W       = 8;
  localparam int          TXQ_DEPTH    = 32;
  localparam int          RATE_W       = 4;
  localparam int          DIV_W        = 12;

  // Status word bit positions
  localparam int          SR_CTS       = 7;
  localparam int          SR_BREAK     = 6;
  localparam int          SR_FRAMING   = 5;
  localparam int          SR_OVERRUN   = 4;
  localparam int          SR_PARITY    = 3;
  localparam int          SR_TX_SHIFT  = 2;
  localparam int          SR_RX_AVAIL  = 1;
  localparam int          SR_TX_HOLD   = 0;

  // Command word bit positions
  localparam int          CMD_COMMON_CLK   = 1;
  localparam int          CMD_ERROR_CLEAR  = 4;
  localparam int          CMD_MODE_REWRITE = 6;

  // Reset values
  localparam logic [7:0]  MODE_RESET   = 8'h00;
  localparam logic [7:0]  CMD_RESET    = 8'h00;
  localparam logic [3:0]  RATE_RESET   = 4'h0;
  localparam logic [7:0]  DATA_RESET   = 8'h00;

  // Crystal divisor for each rate code
  function automatic logic [DIV_W-1:0] rate_factor(input logic [RATE_W-1:0] code);
    case (code)
      4'h0:    rate_factor = 12'h900;
      4'h1:    rate_factor = 12'h600;
      4'h2:    rate_factor = 12'h419;
      4'h3:    rate_factor = 12'h357;
      4'h4:    rate_factor = 12'h300;
      4'h5:    rate_factor = 12'h240;
      4'h6:    rate_factor = 12'h180;
      4'h7:    rate_factor = 12'h0C0;
      4'h8:    rate_factor = 12'h060;
      4'h9:    rate_factor = 12'h040;
      4'hA:    rate_factor = 12'h030;
      4'hB:    rate_factor = 12'h020;
      4'hC:    rate_factor = 12'h018;
      4'hD:    rate_factor = 12'h010;
      4'hE:    rate_factor = 12'h00C;
      default: rate_factor = 12'h006;
    endcase
  endfunction
endpackage

// ==== dasb_top.sv ====
// Functional notes
// - Each channel has a status word the host can only read.
// - Status bits 7..0: CTS, break, framing, overrun, parity, shifter empty, rx avail, holding not full.
// - Shifter-empty flag is 1 while the transmit shift register is empty.
// - Each channel has a rate code choosing one of 16 baud clocks.
// - With common clock off, receiver uses the auxiliary pin, transmitter the baud clock.
// - Rate write keeps only the low four data bits.
// - Codes 0..15 divide the crystal by the sixteen listed divisors.
// - First control write after reset goes to the mode register.
// - After the mode word, control writes are commands until one has bit 6 set.
// - Command with bit 6 set sends the next control write to mode.
// - A received break sets both break and framing flags.
// - Break flag clears once the line is high for one receive clock.
module dasb_top (
  input  wire logic       CLK,
  input  wire logic       RST,
  input  wire logic       CS_A_N,
  input  wire logic       CS_B_N,
  input  wire logic       RATE_CS_N,
  input  wire logic       CTRL_DATA_SEL,
  input  wire logic       RD_N,
  input  wire logic       WR_N,
  input  wire logic [7:0] DATA_IN,
  output logic      [7:0] DATA_OUT,
  output logic            DATA_OE,
  input  wire logic [1:0] CTS_N,
  input  wire logic [1:0] AUX_CLK,
  input  wire logic [1:0] RX_LINE,
  output logic [1:0][7:0] TX_DATA,
  output logic      [1:0] TX_VALID,
  input  wire logic [1:0] TX_READY,
  input  wire logic [1:0] TX_SHIFT_EMPTY,
  input  wire logic [1:0][7:0] RX_DATA,
  input  wire logic [1:0] RX_STROBE,
  input  wire logic [1:0] RX_PARITY_ERR,
  input  wire logic [1:0] RX_FRAMING_ERR,
  input  wire logic [1:0] RX_BREAK,
  output logic      [1:0] TX_BAUD_TICK,
  output logic      [1:0] RX_BAUD_TICK,
  output logic [1:0][7:0] MODE_WORD,
  output logic [1:0][7:0] CMD_WORD
);
  typedef struct packed {
    logic             wr_s1;
    logic             wr_s2;
    logic             wr_prev;
    logic             rd_s1;
    logic             rd_s2;
    logic             rd_prev;
    logic [2:0]       cs_s1;
    logic [2:0]       cs_s2;
    logic             cd_s1;
    logic             cd_s2;
    logic [7:0]       din_s1;
    logic [7:0]       din_s2;
    logic [1:0]       cts_s1;
    logic [1:0]       cts_s2;
    logic [1:0]       aux_s1;
    logic [1:0]       aux_s2;
    logic [1:0]       aux_prev;
    logic [1:0]       line_s1;
    logic [1:0]       line_s2;
    logic [27:0]      xacc;
    logic             xtick;
    logic [1:0][11:0] div_cnt;
    logic [1:0][3:0]  rate;
    logic [1:0][7:0]  mode;
    logic [1:0][7:0]  cmd;
    logic [1:0][7:0]  rx_hold;
    logic [1:0]       expect_mode;
    logic [1:0]       avail;
    logic [1:0]       par_err;
    logic [1:0]       oe;
    logic [1:0]       frm_err;
    logic [1:0]       brk;
    logic [1:0]       baud_tick;
    logic [1:0]       rx_tick;
    logic [7:0]       dout;
    logic             doe;
  } dasb_st_t;

  dasb_st_t        st_reg;
  dasb_st_t        st_next;
  logic            wr_ev;
  logic            rd_end;
  logic            rd_act;
  logic [1:0]      ch_hit;
  logic            rate_hit;
  logic [1:0]      ctrl_wr;
  logic [1:0]      hold_wr;
  logic [1:0]      rate_wr;
  logic [1:0]      rxh_rd_end;
  logic [1:0]      hold_room;
  logic [1:0][7:0] status;
  logic [28:0]     xsum;

  // Bus decode from synchronised strobes
  assign wr_ev    = st_reg.wr_s2 && !st_reg.wr_prev;
  assign rd_end   = st_reg.rd_s2 && !st_reg.rd_prev;
  assign rd_act   = !st_reg.rd_s2;
  assign ch_hit   = {st_reg.cs_s2[0] && !st_reg.cs_s2[1], !st_reg.cs_s2[0]};
  assign rate_hit = st_reg.cs_s2[0] && st_reg.cs_s2[1] && !st_reg.cs_s2[2];
  assign xsum     = {1'b0, st_reg.xacc} + {1'b0, dasb_pkg::XTAL_HZ};

  for (genvar c = 0; c < dasb_pkg::NUM_CH; c++) begin : g_ch
    dasb_fifo_if #(.W(dasb_pkg::DATA_W)) q ();
    dasb_fifo #(.W(dasb_pkg::DATA_W), .DEPTH(dasb_pkg::TXQ_DEPTH)) u_txq (
      .CLK (CLK),
      .RST (RST),
      .q   (q.fifo)
    );
    assign ctrl_wr[c]    = wr_ev && ch_hit[c] && st_reg.cd_s2;
    assign hold_wr[c]    = wr_ev && ch_hit[c] && !st_reg.cd_s2;
    assign rate_wr[c]    = wr_ev && rate_hit && (st_reg.cd_s2 == 1'(c));
    assign rxh_rd_end[c] = rd_end && ch_hit[c] && !st_reg.cd_s2;
    assign q.wdata       = st_reg.din_s2;
    assign q.wvalid      = hold_wr[c];
    assign hold_room[c]  = q.wready;
    assign TX_DATA[c]    = q.rdata;
    assign TX_VALID[c]   = q.rvalid;
    assign q.rready      = TX_READY[c];
    assign status[c]     = {!st_reg.cts_s2[c], st_reg.brk[c], st_reg.frm_err[c],
                            st_reg.oe[c], st_reg.par_err[c], TX_SHIFT_EMPTY[c],
                            st_reg.avail[c], hold_room[c]};
  end

  always_comb begin
    st_next          = st_reg;
    st_next.wr_s1    = WR_N;
    st_next.wr_s2    = st_reg.wr_s1;
    st_next.wr_prev  = st_reg.wr_s2;
    st_next.rd_s1    = RD_N;
    st_next.rd_s2    = st_reg.rd_s1;
    st_next.rd_prev  = st_reg.rd_s2;
    st_next.cs_s1    = {RATE_CS_N, CS_B_N, CS_A_N};
    st_next.cs_s2    = st_reg.cs_s1;
    st_next.cd_s1    = CTRL_DATA_SEL;
    st_next.cd_s2    = st_reg.cd_s1;
    st_next.din_s1   = DATA_IN;
    st_next.din_s2   = st_reg.din_s1;
    st_next.cts_s1   = CTS_N;
    st_next.cts_s2   = st_reg.cts_s1;
    st_next.aux_s1   = AUX_CLK;
    st_next.aux_s2   = st_reg.aux_s1;
    st_next.aux_prev = st_reg.aux_s2;
    st_next.line_s1  = RX_LINE;
    st_next.line_s2  = st_reg.line_s1;
    // Crystal rate enable by phase accumulation
    if (xsum >= {1'b0, dasb_pkg::CLK_HZ}) begin
      st_next.xacc  = 28'(xsum - {1'b0, dasb_pkg::CLK_HZ});
      st_next.xtick = 1'b1;
    end else begin
      st_next.xacc  = xsum[27:0];
      st_next.xtick = 1'b0;
    end
    for (int c = 0; c < dasb_pkg::NUM_CH; c++) begin
      st_next.baud_tick[c] = 1'b0;
      if (st_reg.xtick) begin
        if (st_reg.div_cnt[c] >= dasb_pkg::rate_factor(st_reg.rate[c]) - 12'h001) begin
          st_next.div_cnt[c]   = '0;
          st_next.baud_tick[c] = 1'b1;
        end else begin
          st_next.div_cnt[c] = st_reg.div_cnt[c] + 12'h001;
        end
      end
      if (st_reg.cmd[c][dasb_pkg::CMD_COMMON_CLK]) begin
        st_next.rx_tick[c] = st_next.baud_tick[c];
      end else begin
        st_next.rx_tick[c] = st_reg.aux_s2[c] && !st_reg.aux_prev[c];
      end
      if (rate_wr[c]) begin
        st_next.rate[c] = st_reg.din_s2[3:0];
      end
      if (ctrl_wr[c]) begin
        if (st_reg.expect_mode[c]) begin
          st_next.mode[c]        = st_reg.din_s2;
          st_next.expect_mode[c] = 1'b0;
        end else begin
          st_next.cmd[c] = st_reg.din_s2;
          if (st_reg.din_s2[dasb_pkg::CMD_MODE_REWRITE]) begin
            st_next.expect_mode[c] = 1'b1;
          end
          if (st_reg.din_s2[dasb_pkg::CMD_ERROR_CLEAR]) begin
            st_next.par_err[c] = 1'b0;
            st_next.oe[c]      = 1'b0;
            st_next.frm_err[c] = 1'b0;
          end
        end
      end
      if (rxh_rd_end[c]) begin
        st_next.avail[c] = 1'b0;
      end
      if (RX_STROBE[c]) begin
        if (st_reg.avail[c] && !rxh_rd_end[c]) begin
          st_next.oe[c] = 1'b1;
        end
        st_next.rx_hold[c] = RX_DATA[c];
        st_next.avail[c]   = 1'b1;
      end
      if (RX_PARITY_ERR[c]) begin
        st_next.par_err[c] = 1'b1;
      end
      if (RX_FRAMING_ERR[c]) begin
        st_next.frm_err[c] = 1'b1;
      end
      if (RX_BREAK[c]) begin
        st_next.brk[c]     = 1'b1;
        st_next.frm_err[c] = 1'b1;
      end else if (st_reg.brk[c] && st_reg.line_s2[c] && st_reg.rx_tick[c]) begin
        st_next.brk[c] = 1'b0;
      end
    end
    // Read data path; status has no write path at all
    st_next.doe  = 1'b0;
    st_next.dout = dasb_pkg::DATA_RESET;
    if (rd_act && ch_hit[0]) begin
      st_next.doe  = 1'b1;
      st_next.dout = st_reg.cd_s2 ? status[0] : st_reg.rx_hold[0];
    end else if (rd_act && ch_hit[1]) begin
      st_next.doe  = 1'b1;
      st_next.dout = st_reg.cd_s2 ? status[1] : st_reg.rx_hold[1];
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      st_reg             <= '0;
      st_reg.wr_s1       <= 1'b1;
      st_reg.wr_s2       <= 1'b1;
      st_reg.wr_prev     <= 1'b1;
      st_reg.rd_s1       <= 1'b1;
      st_reg.rd_s2       <= 1'b1;
      st_reg.rd_prev     <= 1'b1;
      st_reg.cs_s1       <= 3'h7;
      st_reg.cs_s2       <= 3'h7;
      st_reg.cts_s1      <= 2'h3;
      st_reg.cts_s2      <= 2'h3;
      st_reg.rate        <= {dasb_pkg::RATE_RESET, dasb_pkg::RATE_RESET};
      st_reg.mode        <= {dasb_pkg::MODE_RESET, dasb_pkg::MODE_RESET};
      st_reg.cmd         <= {dasb_pkg::CMD_RESET, dasb_pkg::CMD_RESET};
      st_reg.expect_mode <= 2'h3;
    end else begin
      st_reg <= st_next;
    end
  end

  assign DATA_OUT     = st_reg.dout;
  assign DATA_OE      = st_reg.doe;
  assign TX_BAUD_TICK = st_reg.baud_tick;
  assign RX_BAUD_TICK = st_reg.rx_tick;
  assign MODE_WORD    = st_reg.mode;
  assign CMD_WORD     = st_reg.cmd;

  property p_mode_first;
    @(posedge CLK) disable iff (RST)
    ctrl_wr[0] && st_reg.expect_mode[0] |=> st_reg.mode[0] == $past(st_reg.din_s2) && !st_reg.expect_mode[0];
  endproperty
  a_mode_first: assert property (p_mode_first) else $error("mode word not taken first");

  property p_cmd_after;
    @(posedge CLK) disable iff (RST)
    ctrl_wr[1] && !st_reg.expect_mode[1] |=> st_reg.cmd[1] == $past(st_reg.din_s2);
  endproperty
  a_cmd_after: assert property (p_cmd_after) else $error("command word not stored");

  property p_rewrite;
    @(posedge CLK) disable iff (RST)
    ctrl_wr[0] && !st_reg.expect_mode[0] && st_reg.din_s2[6] |=> st_reg.expect_mode[0];
  endproperty
  a_rewrite: assert property (p_rewrite) else $error("mode rewrite not armed");

  property p_err_clear;
    @(posedge CLK) disable iff (RST)
    ctrl_wr[0] && !st_reg.expect_mode[0] && st_reg.din_s2[4] && !RX_PARITY_ERR[0] && !RX_STROBE[0]
      |=> !st_reg.par_err[0] && !st_reg.oe[0];
  endproperty
  a_err_clear: assert property (p_err_clear) else $error("error flags not cleared");

  property p_rate_low;
    @(posedge CLK) disable iff (RST)
    rate_wr[0] |=> st_reg.rate[0] == $past(st_reg.din_s2[3:0]);
  endproperty
  a_rate_low: assert property (p_rate_low) else $error("rate code not loaded from low bits");

  property p_baud_gap;
    @(posedge CLK) disable iff (RST)
    st_reg.baud_tick[0] |=> !st_reg.baud_tick[0] [*8];
  endproperty
  a_baud_gap: assert property (p_baud_gap) else $error("baud ticks too close");

  property p_break_sets;
    @(posedge CLK) disable iff (RST)
    RX_BREAK[0] |=> st_reg.brk[0] && st_reg.frm_err[0] && status[0][6] && status[0][5];
  endproperty
  a_break_sets: assert property (p_break_sets) else $error("break did not set both flags");

  property p_rx_aux;
    @(posedge CLK) disable iff (RST)
    !st_reg.cmd[0][1] && st_reg.aux_s2[0] && !st_reg.aux_prev[0] |=> st_reg.rx_tick[0];
  endproperty
  a_rx_aux: assert property (p_rx_aux) else $error("receiver not clocked from aux pin");

  property p_avail;
    @(posedge CLK) disable iff (RST)
    RX_STROBE[0] |=> status[0][1] ##1 status[0][1] || $past(rxh_rd_end[0]);
  endproperty
  a_avail: assert property (p_avail) else $error("receive available not raised");
endmodule

// ==== tb.sv ====
module tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                CLK = 1'b0;
  logic                RST = 1'b1;
  logic                CS_A_N, CS_B_N, RATE_CS_N, CTRL_DATA_SEL, RD_N, WR_N, DATA_OE, oe_d;
  logic          [7:0] DATA_IN, DATA_OUT, d;
  logic          [1:0] CTS_N, AUX_CLK, RX_LINE, TX_VALID, TX_READY, TX_SHIFT_EMPTY, TX_BAUD_TICK, RX_BAUD_TICK;
  logic          [1:0] RX_STROBE, RX_PARITY_ERR, RX_FRAMING_ERR, RX_BREAK, brk, frm, oe, par, rxa, nxt_mode;
  logic     [1:0][7:0] TX_DATA, RX_DATA, MODE_WORD, CMD_WORD, em, ec, rx_hold;
  logic         [31:0] words_d;
  logic         [31:0] rdq[$], wq[$], txq[$];
  int                  num_errors = 0, cmp_count = 0, txn = 0;
  int                  rx_cnt[2], tx_cnt[2];
  int                  divs[16] = '{2304, 1536, 1049, 855, 768, 576, 384, 192, 96, 64, 48, 32, 24, 16, 12, 6};

  always #2.5 CLK = ~CLK;

  dasb_host host_inst (.CLK(CLK), .CS_A_N(CS_A_N), .CS_B_N(CS_B_N), .RATE_CS_N(RATE_CS_N),
    .CTRL_DATA_SEL(CTRL_DATA_SEL), .RD_N(RD_N), .WR_N(WR_N), .DATA_IN(DATA_IN));

  dasb_top dasb_top_inst (.CLK(CLK), .RST(RST), .CS_A_N(CS_A_N), .CS_B_N(CS_B_N), .RATE_CS_N(RATE_CS_N),
    .CTRL_DATA_SEL(CTRL_DATA_SEL), .RD_N(RD_N), .WR_N(WR_N), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT),
    .DATA_OE(DATA_OE), .CTS_N(CTS_N), .AUX_CLK(AUX_CLK), .RX_LINE(RX_LINE), .TX_DATA(TX_DATA),
    .TX_VALID(TX_VALID), .TX_READY(TX_READY), .TX_SHIFT_EMPTY(TX_SHIFT_EMPTY), .RX_DATA(RX_DATA),
    .RX_STROBE(RX_STROBE), .RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAMING_ERR(RX_FRAMING_ERR),
    .RX_BREAK(RX_BREAK), .TX_BAUD_TICK(TX_BAUD_TICK), .RX_BAUD_TICK(RX_BAUD_TICK),
    .MODE_WORD(MODE_WORD), .CMD_WORD(CMD_WORD));

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return q.size() > 0 ? q.pop_front() : 32'hXXXXXXXX;
  endfunction

  function automatic logic [7:0] status(input int ch);
    return {~CTS_N[ch], brk[ch], frm[ch], oe[ch], par[ch], TX_SHIFT_EMPTY[ch], rxa[ch], (ch != 0 || txn < 32)};
  endfunction

  // Result watcher, between edges where outputs and stimulus have settled
  always @(negedge CLK) begin
    #1;
    if (DATA_OE === 1'b1 && oe_d !== 1'b1) begin
      check("read data", pop(rdq), 32'(DATA_OUT));
    end
    if (RST === 1'b0 && {MODE_WORD, CMD_WORD} !== words_d) begin
      check("mode and command", pop(wq), {MODE_WORD, CMD_WORD});
    end
    if (TX_VALID[0] === 1'b1 && TX_READY[0] === 1'b1) begin
      check("transmit head", pop(txq), 32'(TX_DATA[0]));
    end
    oe_d = DATA_OE;
    words_d = {MODE_WORD, CMD_WORD};
    for (int i = 0; i < 2; i++) begin
      rx_cnt[i] += int'(RX_BAUD_TICK[i] === 1'b1);
      tx_cnt[i] += int'(TX_BAUD_TICK[i] === 1'b1);
    end
  end

  // Control write with expected word routing
  task automatic ctl(input int ch, input logic [7:0] v);
    if (nxt_mode[ch]) begin
      em[ch] = v;
      nxt_mode[ch] = 1'b0;
    end else begin
      ec[ch] = v;
      nxt_mode[ch] = v[dasb_pkg::CMD_MODE_REWRITE];
      if (v[dasb_pkg::CMD_ERROR_CLEAR]) begin
        {oe[ch], frm[ch], par[ch]} = 3'h0;
      end
    end
    wq.push_back({em, ec});
    host_inst.access(ch, 1'b1, 1'b1, v);
  endtask

  task automatic rd_status(input int ch);
    @(negedge CLK);
    CTS_N[ch] = 1'($urandom);
    TX_SHIFT_EMPTY[ch] = 1'($urandom);
    repeat (4) @(negedge CLK);
    rdq.push_back(32'(status(ch)));
    host_inst.access(ch, 1'b1, 1'b0, 8'h00);
  endtask

  task automatic rd_data(input int ch);
    rdq.push_back(32'(rx_hold[ch]));
    host_inst.access(ch, 1'b0, 1'b0, 8'h00);
    rxa[ch] = 1'b0;
  endtask

  // Kind 0 character, 1 parity, 2 framing, 3 break
  task automatic rx_event(input int ch, input int kind);
    @(negedge CLK);
    case (kind)
      0: begin
        RX_DATA[ch] = 8'($urandom);
        RX_STROBE[ch] = 1'b1;
        oe[ch] = oe[ch] | rxa[ch];
        rxa[ch] = 1'b1;
        rx_hold[ch] = RX_DATA[ch];
      end
      1: begin
        RX_PARITY_ERR[ch] = 1'b1;
        par[ch] = 1'b1;
      end
      2: begin
        RX_FRAMING_ERR[ch] = 1'b1;
        frm[ch] = 1'b1;
      end
      default: begin
        RX_BREAK[ch] = 1'b1;
        {brk[ch], frm[ch]} = 2'h3;
      end
    endcase
    @(negedge CLK);
    {RX_STROBE[ch], RX_PARITY_ERR[ch], RX_FRAMING_ERR[ch], RX_BREAK[ch]} = 4'h0;
  endtask

  // Interval between two transmit ticks against the crystal divisor
  task automatic measure(input int ch, input int code);
    int n;
    int want;
    want = int'(divs[code] * real'(dasb_pkg::CLK_HZ) / real'(dasb_pkg::XTAL_HZ));
    repeat (2) begin
      n = 0;
      @(negedge CLK);
      while (TX_BAUD_TICK[ch] !== 1'b1 && n < 20000) begin
        @(negedge CLK);
        n++;
      end
    end
    n++;
    check("baud interval", 32'(want), 32'((n - want) inside {[-2:2]} ? want : n));
  endtask

  initial begin
    #450000;
    num_errors++;
    $display("Error watchdog expected end seen timeout");
    finish_test();
  end

  initial begin
    {CTS_N, AUX_CLK, RX_LINE, TX_READY, TX_SHIFT_EMPTY} = 10'h303;
    {RX_STROBE, RX_PARITY_ERR, RX_FRAMING_ERR, RX_BREAK} = 8'h00;
    RX_DATA = 16'h0000;
    {brk, frm, oe, par, rxa} = 10'h000;
    {em, ec, rx_hold} = 48'h0;
    nxt_mode = 2'h3;
    void'($urandom(46));
    repeat (16) @(negedge CLK);
    RST = 1'b0;
    repeat (4) @(negedge CLK);
    check("words after reset", 32'h0, {MODE_WORD, CMD_WORD});
    rd_status(1);
    host_inst.access(2, 1'b1, 1'b1, {4'($urandom), 4'hF});
    measure(1, 15);
    for (int c = 15; c >= 9; c--) begin
      host_inst.access(2, 1'b0, 1'b1, {4'($urandom), 4'(c)});
      measure(0, c);
    end
    ctl(0, 8'h4E);
    ctl(0, 8'h05);
    ctl(0, 8'h25);
    ctl(0, 8'h40);
    ctl(0, 8'h7F);
    ctl(0, 8'h05);
    ctl(1, 8'hCF);
    ctl(1, 8'h27);
    rd_status(0);
    rx_event(0, 0);
    rd_status(0);
    rd_data(0);
    rd_status(0);
    rx_event(0, 0);
    rx_event(0, 0);
    rd_status(0);
    rd_data(0);
    rx_event(0, 1);
    rx_event(0, 2);
    rd_status(0);
    ctl(0, 8'h01);
    rd_status(0);
    ctl(0, 8'h15);
    rd_status(0);
    rx_event(0, 3);
    rd_status(0);
    RX_LINE[0] = 1'b1;
    rx_cnt[0] = 0;
    repeat (5) begin
      AUX_CLK[0] = 1'b1;
      repeat (4) @(negedge CLK);
      AUX_CLK[0] = 1'b0;
      repeat (4) @(negedge CLK);
    end
    repeat (4) @(negedge CLK);
    brk[0] = 1'b0;
    check("aux receive ticks", 32'h5, 32'(rx_cnt[0]));
    rd_status(0);
    rx_cnt[1] = 0;
    tx_cnt[1] = 0;
    repeat (3000) begin
      @(negedge CLK);
      AUX_CLK[1] = 1'($urandom);
    end
    check("baud ticks in window", 32'h1, 32'(tx_cnt[1] inside {[4:5]}));
    check("common receive ticks", 32'(tx_cnt[1]), 32'((rx_cnt[1] - tx_cnt[1]) inside {[-1:1]} ? tx_cnt[1] : rx_cnt[1]));
    for (int i = 0; i < 33; i++) begin
      d = 8'($urandom);
      if (i < 32) begin
        txq.push_back(32'(d));
      end
      host_inst.access(0, 1'b0, 1'b1, d);
    end
    txn = 32;
    rd_status(0);
    for (int i = 0; i < 400 && TX_VALID[0] !== 1'b0; i++) begin
      @(negedge CLK);
      TX_READY[0] = 1'($urandom);
    end
    @(negedge CLK);
    TX_READY[0] = 1'b0;
    txn = 0;
    rd_status(0);
    rd_status(1);
    repeat (10) @(negedge CLK);
    check("pending results", 32'h0, 32'(rdq.size() + wq.size() + txq.size()));
    finish_test();
  end
endmodule
